//--- rmc_pkg.sv
// constants shared by the redriver mux control register bank
// assumes a 25 MHz system clock and the two-wire register port
package rmc_pkg;
	// register offsets on the two-wire port
	localparam logic [7:0] REG_GENERAL = 8'h0A;
	localparam logic [7:0] REG_EQ_L1_L3 = 8'h10;
	localparam logic [7:0] REG_EQ_L0_L2 = 8'h11;
	localparam logic [7:0] REG_SNOOP = 8'h12;
	localparam logic [7:0] REG_LANE_CTL = 8'h13;
	// values after reset
	localparam logic [7:0] GENERAL_RESET = 8'h01;
	localparam logic [7:0] EQ_RESET = 8'h00;
	localparam logic [7:0] LANE_CTL_RESET = 8'h00;
	localparam logic [1:0] POWER_RESET = 2'h0;
	localparam logic [4:0] LANES_RESET = 5'h00;
	// field positions
	localparam int EQ_SRC_BIT = 4;
	localparam int DP_SRC_BIT = 3;
	localparam int ORIENT_BIT = 2;
	localparam int SNOOP_OFF_BIT = 7;
	// mux configuration codes
	localparam logic [1:0] MUX_OFF = 2'h0;
	localparam logic [1:0] MUX_USB = 2'h1;
	localparam logic [1:0] MUX_DP4 = 2'h2;
	localparam logic [1:0] MUX_DP2_USB = 2'h3;
	// snooped link configuration addresses and values
	localparam logic [19:0] AUX_ADDR_POWER = 20'h0_0600;
	localparam logic [19:0] AUX_ADDR_LANES = 20'h0_0101;
	localparam logic [1:0] POWER_DOWN = 2'h2;
	// pin debounce: longest time, so the count rounds down
	localparam int unsigned CLOCK_HZ = 25_000_000;
	localparam int unsigned DEBOUNCE_MS = 16;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLOCK_HZ / 1000);
	localparam int DEBOUNCE_CNT_W = 19;
	// two-wire target state machine
	typedef enum logic [6:0] {
		RMC_IDLE = 7'h01,
		RMC_ADDR = 7'h02,
		RMC_ADDR_ACK = 7'h04,
		RMC_WR_BYTE = 7'h08,
		RMC_WR_ACK = 7'h10,
		RMC_RD_BYTE = 7'h20,
		RMC_RD_ACK = 7'h40
	} rmc_i2c_e;
endpackage

//--- rmc_debounce.sv
// pin debouncer: output follows the raw pin once it has held steady
// assumes the raw pin is already synchronous to clock_in
module rmc_debounce #(
	parameter int unsigned CYCLES = rmc_pkg::DEBOUNCE_CYCLES
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic raw_in,
	output logic stable_out
);
	import rmc_pkg::*;

	typedef struct packed {
		logic [DEBOUNCE_CNT_W-1:0] cnt;
		logic stable;
	} rmc_deb_s;

	rmc_deb_s deb_reg;
	rmc_deb_s deb_next;

	// restart the count on every bounce; commit when it expires
	always_comb begin
		deb_next = deb_reg;
		if (raw_in == deb_reg.stable) begin
			deb_next.cnt = '0;
		end else if (deb_reg.cnt == DEBOUNCE_CNT_W'(CYCLES - 1)) begin
			deb_next.cnt = '0;
			deb_next.stable = raw_in;
		end else begin
			deb_next.cnt = deb_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			deb_reg <= '0;
		end else begin
			deb_reg <= deb_next;
		end
	end

	assign stable_out = deb_reg.stable;
endmodule

//--- rmc_regs.sv
// redriver mux control register bank with two-wire target port
// assumes scl/sda are synchronous to clock_in; sda is open drain

module rmc_regs #(
	parameter logic [6:0] TARGET_ADDR = 7'h2C, // arbitrary value
	parameter int unsigned DEBOUNCE_LEN = rmc_pkg::DEBOUNCE_CYCLES
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe_out,
	input wire logic config_pin_upper_in,
	input wire logic config_pin_lower_in,
	input wire logic orientation_pin_in,
	input wire logic [1:0] display_eq_pins_in,
	input wire logic aux_wr_valid_in,
	input wire logic [19:0] aux_wr_addr_in,
	input wire logic [7:0] aux_wr_data_in,
	output logic [3:0] lane_enable_out,
	output logic usb_enable_out,
	output logic orientation_out,
	output logic [15:0] lane_eq_out,
	output logic [1:0] aux_sbu_mode_out
);
	import rmc_pkg::*;

	typedef struct packed {
		rmc_i2c_e st;
		logic scl_q;
		logic sda_q;
		logic [3:0] bits;
		logic [7:0] sh;
		logic rw;
		logic first;
		logic [7:0] ptr;
		logic sda_oe;
		logic [7:0] gen;
		logic [7:0] eq13;
		logic [7:0] eq02;
		logic [7:0] lanectl;
		logic [1:0] power;
		logic [4:0] lanes;
		logic strap_done;
		logic [1:0] eq_strap;
		logic upper_q;
		logic up_q;
		logic lo_q;
		logic or_q;
		logic [3:0] lane_en;
		logic usb_en;
		logic orient;
		logic [15:0] eq_out;
	} rmc_state_s;

	rmc_state_s st_reg;
	rmc_state_s st_next;
	logic up_db;
	logic lo_db;
	logic or_db;

	// one debouncer per mux and orientation pin; a change applies only once it settles
	rmc_debounce #(.CYCLES(DEBOUNCE_LEN)) u_deb_up (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.raw_in(config_pin_upper_in),
		.stable_out(up_db)
	);
	rmc_debounce #(.CYCLES(DEBOUNCE_LEN)) u_deb_lo (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.raw_in(config_pin_lower_in),
		.stable_out(lo_db)
	);
	rmc_debounce #(.CYCLES(DEBOUNCE_LEN)) u_deb_or (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.raw_in(orientation_pin_in),
		.stable_out(or_db)
	);

	// read mux; unmapped offsets read zero
	function automatic logic [7:0] rd_val(input rmc_state_s s,
			input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			REG_GENERAL: v = s.gen;
			REG_EQ_L1_L3: v = s.eq13;
			REG_EQ_L0_L2: v = s.eq02;
			REG_SNOOP: v = {1'b0, s.power, s.lanes};
			REG_LANE_CTL: v = s.lanectl;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// lanes kept by the snooped count; zero means nothing snooped yet
	function automatic logic [3:0] count_mask(input logic [4:0] c);
		logic [3:0] m;
		m = 4'hF;
		if (c == 5'h01) begin
			m = 4'h1;
		end else if (c == 5'h02) begin
			m = 4'h3;
		end
		return m;
	endfunction

	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic [7:0] rd_now;
	logic dp_on;
	logic [3:0] base_lanes;
	logic [1:0] eq_src;
	logic [3:0] strap_level;

	// edges and bus conditions, from the previous pin samples
	always_comb begin
		scl_rise = i2c_scl_in & ~st_reg.scl_q;
		scl_fall = ~i2c_scl_in & st_reg.scl_q;
		i2c_start = st_reg.scl_q & i2c_scl_in & st_reg.sda_q & ~i2c_sda_in;
		i2c_stop = st_reg.scl_q & i2c_scl_in & ~st_reg.sda_q & i2c_sda_in;
		rd_now = rd_val(st_reg, st_reg.ptr);
		strap_level = {2'b00, st_reg.eq_strap};
	end

	// lane plan from mux select and display enable source
	always_comb begin
		eq_src = st_reg.gen[1:0];
		if (st_reg.gen[DP_SRC_BIT]) begin
			dp_on = st_reg.up_q;
		end else begin
			dp_on = st_reg.gen[1];
		end
		if (!dp_on || eq_src == MUX_OFF) begin
			base_lanes = 4'h0;
		end else if (eq_src[0]) begin
			base_lanes = 4'h3;
		end else begin
			base_lanes = 4'hF;
		end
	end

	// next state: port, register writes, pins, snoop, outputs
	always_comb begin
		st_next = st_reg;
		st_next.scl_q = i2c_scl_in;
		st_next.sda_q = i2c_sda_in;
		if (i2c_start) begin
			st_next.st = RMC_ADDR;
			st_next.bits = 4'h0;
			st_next.sda_oe = 1'b0;
		end else if (i2c_stop) begin
			st_next.st = RMC_IDLE;
			st_next.sda_oe = 1'b0;
		end else begin
			unique case (st_reg.st)
				RMC_IDLE: begin
					st_next.sda_oe = 1'b0;
				end
				RMC_ADDR: begin
					if (scl_rise) begin
						st_next.sh = {st_reg.sh[6:0], i2c_sda_in};
						st_next.bits = st_reg.bits + 1'b1;
					end
					if (scl_fall && st_reg.bits == 4'h8) begin
						if (st_reg.sh[7:1] == TARGET_ADDR) begin
							st_next.st = RMC_ADDR_ACK;
							st_next.rw = st_reg.sh[0];
							st_next.sda_oe = 1'b1;
						end else begin
							st_next.st = RMC_IDLE;
						end
					end
				end
				RMC_ADDR_ACK: begin
					if (scl_fall) begin
						st_next.bits = 4'h0;
						if (st_reg.rw) begin
							st_next.st = RMC_RD_BYTE;
							st_next.sh = rd_now;
							st_next.sda_oe = ~rd_now[7];
							st_next.ptr = st_reg.ptr + 1'b1;
						end else begin
							st_next.st = RMC_WR_BYTE;
							st_next.first = 1'b1;
							st_next.sda_oe = 1'b0;
						end
					end
				end
				RMC_WR_BYTE: begin
					if (scl_rise) begin
						st_next.sh = {st_reg.sh[6:0], i2c_sda_in};
						st_next.bits = st_reg.bits + 1'b1;
					end
					if (scl_fall && st_reg.bits == 4'h8) begin
						st_next.st = RMC_WR_ACK;
						st_next.sda_oe = 1'b1;
						st_next.bits = 4'h0;
						st_next.first = 1'b0;
						if (st_reg.first) begin
							st_next.ptr = st_reg.sh;
						end else begin
							st_next.ptr = st_reg.ptr + 1'b1;
							unique case (st_reg.ptr)
								REG_GENERAL: begin
									st_next.gen = {3'b000, st_reg.sh[4:0]};
								end
								REG_EQ_L1_L3: begin
									if (st_reg.gen[EQ_SRC_BIT]) begin
										st_next.eq13 = st_reg.sh;
									end
								end
								REG_EQ_L0_L2: begin
									if (st_reg.gen[EQ_SRC_BIT]) begin
										st_next.eq02 = st_reg.sh;
									end
								end
								REG_LANE_CTL: begin
									st_next.lanectl = {st_reg.sh[7], 1'b0, st_reg.sh[5:0]};
								end
								default: begin
									st_next.ptr = st_reg.ptr + 1'b1;
								end
							endcase
						end
					end
				end
				RMC_WR_ACK: begin
					if (scl_fall) begin
						st_next.st = RMC_WR_BYTE;
						st_next.sda_oe = 1'b0;
					end
				end
				RMC_RD_BYTE: begin
					if (scl_fall) begin
						if (st_reg.bits == 4'h7) begin
							st_next.st = RMC_RD_ACK;
							st_next.sda_oe = 1'b0;
						end else begin
							st_next.sh = {st_reg.sh[6:0], 1'b0};
							st_next.sda_oe = ~st_reg.sh[6];
							st_next.bits = st_reg.bits + 1'b1;
						end
					end
				end
				RMC_RD_ACK: begin
					if (scl_rise && i2c_sda_in) begin
						st_next.st = RMC_IDLE; // controller refused more data
					end else if (scl_fall) begin
						st_next.st = RMC_RD_BYTE;
						st_next.sh = rd_now;
						st_next.sda_oe = ~rd_now[7];
						st_next.ptr = st_reg.ptr + 1'b1;
						st_next.bits = 4'h0;
					end
				end
				default: begin
					st_next.st = RMC_IDLE;
					st_next.sda_oe = 1'b0;
				end
			endcase
		end
		// settled pin changes override the register; pins act like writes
		st_next.up_q = up_db;
		st_next.lo_q = lo_db;
		st_next.or_q = or_db;
		if (up_db != st_reg.up_q || lo_db != st_reg.lo_q) begin
			st_next.gen[1:0] = {up_db, lo_db};
		end
		if (or_db != st_reg.or_q) begin
			st_next.gen[ORIENT_BIT] = or_db;
		end
		// strap pins are caught once, the first cycle after reset
		if (!st_reg.strap_done) begin
			st_next.strap_done = 1'b1;
			st_next.eq_strap = display_eq_pins_in;
		end
		if (!st_reg.gen[EQ_SRC_BIT] && st_reg.strap_done) begin
			st_next.eq13 = {strap_level, strap_level};
			st_next.eq02 = {strap_level, strap_level};
		end
		// clear on a falling upper bit first, so a same-cycle capture wins
		st_next.upper_q = st_reg.gen[1];
		if (st_reg.upper_q && !st_reg.gen[1]) begin
			st_next.power = POWER_RESET;
			st_next.lanes = LANES_RESET;
		end
		if (aux_wr_valid_in && aux_wr_addr_in == AUX_ADDR_POWER) begin
			st_next.power = aux_wr_data_in[1:0];
		end
		if (aux_wr_valid_in && aux_wr_addr_in == AUX_ADDR_LANES) begin
			st_next.lanes = aux_wr_data_in[4:0];
		end
		// lane enables: snooped state, or software off bits when snoop is off
		if (st_reg.lanectl[SNOOP_OFF_BIT]) begin
			st_next.lane_en = base_lanes & ~st_reg.lanectl[3:0];
		end else if (st_reg.power == POWER_DOWN) begin
			st_next.lane_en = 4'h0;
		end else begin
			st_next.lane_en = base_lanes & count_mask(st_reg.lanes);
		end
		st_next.usb_en = st_reg.gen[0] && eq_src != MUX_OFF;
		st_next.orient = st_reg.gen[ORIENT_BIT];
		st_next.eq_out = {st_reg.eq13[3:0], st_reg.eq02[3:0],
			st_reg.eq13[7:4], st_reg.eq02[7:4]};
	end

	// one register for all state; reset values per field
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg <= '0;
			st_reg.st <= RMC_IDLE;
			st_reg.scl_q <= 1'b1;
			st_reg.sda_q <= 1'b1;
			st_reg.gen <= GENERAL_RESET;
			st_reg.eq13 <= EQ_RESET;
			st_reg.eq02 <= EQ_RESET;
			st_reg.lanectl <= LANE_CTL_RESET;
			st_reg.power <= POWER_RESET;
			st_reg.lanes <= LANES_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops; sda only ever pulls low
	assign i2c_sda_out = 1'b0;
	assign i2c_sda_oe_out = st_reg.sda_oe;
	assign lane_enable_out = st_reg.lane_en;
	assign usb_enable_out = st_reg.usb_en;
	assign orientation_out = st_reg.orient;
	assign lane_eq_out = st_reg.eq_out;
	assign aux_sbu_mode_out = st_reg.lanectl[5:4];

	// checks
	a_eq_strap_track: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		!st_reg.gen[EQ_SRC_BIT] && st_reg.strap_done |=>
		st_reg.eq02 == {$past(strap_level), $past(strap_level)})
		else $error("eq field not following strap");
	a_mux_off_all: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		st_reg.gen[1:0] == MUX_OFF [*2] |=>
		lane_enable_out == 4'h0 && !usb_enable_out)
		else $error("lanes active with mux off");
	a_power_capture: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		aux_wr_valid_in && aux_wr_addr_in == AUX_ADDR_POWER |=>
		st_reg.power == $past(aux_wr_data_in[1:0]))
		else $error("power state not captured");
	a_lanes_capture: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		aux_wr_valid_in && aux_wr_addr_in == AUX_ADDR_LANES |=>
		st_reg.lanes == $past(aux_wr_data_in[4:0]))
		else $error("lane count not captured");
	a_snoop_clear_fall: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		st_reg.upper_q && !st_reg.gen[1] && !aux_wr_valid_in |=>
		st_reg.power == POWER_RESET && st_reg.lanes == LANES_RESET)
		else $error("snoop fields not cleared");
	a_power_down_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		!st_reg.lanectl[SNOOP_OFF_BIT] && st_reg.power == POWER_DOWN |=>
		lane_enable_out == 4'h0)
		else $error("lanes on in power down");
	a_count_one_lane: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		!st_reg.lanectl[SNOOP_OFF_BIT] && st_reg.power != POWER_DOWN &&
		st_reg.lanes == 5'h01 && base_lanes == 4'hF |=>
		lane_enable_out == 4'h1)
		else $error("lane count not applied");
	a_lane_off_bits: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		st_reg.lanectl[SNOOP_OFF_BIT] |=>
		lane_enable_out == ($past(base_lanes) & ~$past(st_reg.lanectl[3:0])))
		else $error("lane off bits ignored");
	a_reserved_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		st_reg.gen[7:5] == 3'b000 && st_reg.lanectl[6] == 1'b0)
		else $error("reserved bit set");
	a_eq_lane_map: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		##1 lane_eq_out[3:0] == $past(st_reg.eq02[7:4]) &&
		lane_eq_out[15:12] == $past(st_reg.eq13[3:0]))
		else $error("eq output mapping wrong");
	a_orient_out: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		##1 orientation_out == $past(st_reg.gen[ORIENT_BIT]))
		else $error("orientation not applied");
	c_write_ack: cover property (@(posedge clock_in) st_reg.st == RMC_WR_ACK);
	c_read_byte: cover property (@(posedge clock_in) st_reg.st == RMC_RD_BYTE);
	c_power_down: cover property (@(posedge clock_in)
		st_reg.power == POWER_DOWN);
	c_four_lanes: cover property (@(posedge clock_in)
		lane_enable_out == 4'hF);
endmodule

//--- rmc_i2c_host.sv
// two-wire host model that drives the register port of the bank
// assumes the bench resolves the open-drain data wire with a pull-up
module rmc_i2c_host #(
	parameter logic [6:0] TARGET_ADDR = 7'h2C // arbitrary value
) (
	input wire logic clock_in,
	input wire logic sda_wire_in,
	output logic scl_out,
	output logic sda_low_out,
	output logic nack_seen_out,
	output logic rd_done_out,
	output logic [7:0] rd_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// bus idles released, so the pull-up shows high
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		nack_seen_out = 1'b0;
		rd_done_out = 1'b0;
		rd_data_out = 8'h00;
	end
	// every change lands just after a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// data only moves while scl is low
	task automatic bit_out(input logic b);
		sda_low_out = ~b;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		scl_out = 1'b0;
		tick(2);
	endtask
	task automatic bit_in(output logic b);
		sda_low_out = 1'b0;
		tick(2);
		scl_out = 1'b1;
		tick(2);
		b = sda_wire_in;
		tick(2);
		scl_out = 1'b0;
		tick(2);
	endtask
	// a missing acknowledge stays sticky for the bench to judge
	task automatic send(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) bit_out(v[i]);
		bit_in(a);
		if (a !== 1'b0) nack_seen_out = 1'b1;
	endtask
	task automatic start();
		sda_low_out = 1'b0;
		scl_out = 1'b1;
		tick(4);
		sda_low_out = 1'b1;
		tick(4);
		scl_out = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_low_out = 1'b1;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_low_out = 1'b0;
		tick(4);
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] data);
		start();
		send({TARGET_ADDR, 1'b0});
		send(off);
		send(data);
		stop();
	endtask
	// pointer set by a short write, then one byte read and refused
	task automatic rd(input logic [7:0] off);
		logic b;
		start();
		send({TARGET_ADDR, 1'b0});
		send(off);
		stop();
		start();
		send({TARGET_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			bit_in(b);
			rd_data_out[i] = b;
		end
		bit_out(1'b1);
		stop();
		rd_done_out = 1'b1;
		tick(1);
		rd_done_out = 1'b0;
	endtask
endmodule

//--- rmc_regs_test.sv
// self-checking bench for the redriver mux control register bank
// assumes rmc_pkg and the host model rmc_i2c_host are compiled first
module rmc_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import rmc_pkg::*;
	logic clock_in, sys_rst_in, host_low, scl, sda_oe, sda_val;
	logic nack, rd_done, up_pin, lo_pin, or_pin, aux_v, usb, orient;
	logic [1:0] strap, sbu;
	logic [19:0] aux_a;
	logic [7:0] aux_d, rd_data, ea, eb;
	logic [3:0] lanes, e4, lx;
	logic [15:0] eq;
	logic [7:0] exp_q[$];
	int seed = 35435;
	int err_total = 0;
	int n_checks = 0;
	// open-drain wire with pull-up, pulled by either party
	wire logic sda_w = ~(host_low | (sda_oe & ~sda_val));

	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// short debounce keeps the pin test brief
	rmc_regs #(.DEBOUNCE_LEN(8)) rmc_regs_inst (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.i2c_scl_in(scl), .i2c_sda_in(sda_w),
		.i2c_sda_out(sda_val), .i2c_sda_oe_out(sda_oe),
		.config_pin_upper_in(up_pin), .config_pin_lower_in(lo_pin),
		.orientation_pin_in(or_pin), .display_eq_pins_in(strap),
		.aux_wr_valid_in(aux_v), .aux_wr_addr_in(aux_a),
		.aux_wr_data_in(aux_d), .lane_enable_out(lanes),
		.usb_enable_out(usb), .orientation_out(orient),
		.lane_eq_out(eq), .aux_sbu_mode_out(sbu)
	);
	rmc_i2c_host rmc_i2c_host_inst (
		.clock_in(clock_in), .sda_wire_in(sda_w), .scl_out(scl),
		.sda_low_out(host_low), .nack_seen_out(nack),
		.rd_done_out(rd_done), .rd_data_out(rd_data)
	);

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] want,
		input string what);
		n_checks++;
		if (got !== want) begin
			err_total++;
			$display("BAD %0t %s got %h want %h", $time, what, got, want);
		end
	endtask
	// the expected byte is noted before the read starts
	task automatic rd(input logic [7:0] off, input logic [7:0] want);
		exp_q.push_back(want);
		rmc_i2c_host_inst.rd(off);
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] v);
		rmc_i2c_host_inst.wr(off, v);
		tick(3);
	endtask
	// a released snoop bus shows junk, never the last value
	task automatic aux(input logic [19:0] a, input logic [7:0] d);
		aux_v = 1'b1;
		aux_a = a;
		aux_d = d;
		tick(1);
		aux_v = 1'b0;
		aux_a = ~a;
		aux_d = ~d;
		tick(3);
	endtask
	// every finished read is judged against the oldest note
	always @(posedge clock_in) begin
		if (rd_done === 1'b1) begin
			chk({8'h00, rd_data}, {8'h00, exp_q.pop_front()}, "read");
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// the tests need about 7700 cycles
	initial begin
		tick(40000);
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		give_verdict();
	end

	initial begin
		sys_rst_in = 1'b1;
		up_pin = 1'b0;
		lo_pin = 1'b0;
		or_pin = 1'b0;
		aux_v = 1'b0;
		aux_a = 20'h0_0000;
		aux_d = 8'h00;
		strap = 2'($random(seed));
		e4 = {2'b00, strap};
		tick(3);
		chk(eq, 16'h0000, "reset eq");
		chk({11'h000, usb, lanes}, 16'h0000, "reset en");
		tick(3);
		sys_rst_in = 1'b0;
		tick(4);
		chk({11'h000, usb, lanes}, 16'h0010, "usb only");
		rd(REG_GENERAL, GENERAL_RESET);
		rd(REG_SNOOP, 8'h00);
		rd(REG_LANE_CTL, LANE_CTL_RESET);
		rd(REG_EQ_L1_L3, {e4, e4});
		chk(eq, {4{e4}}, "strap eq");
		$display("test reset done");
		ea = 8'($random(seed));
		eb = 8'($random(seed));
		wr(REG_EQ_L0_L2, ea);
		rd(REG_EQ_L0_L2, {e4, e4});
		wr(REG_GENERAL, 8'h11);
		wr(REG_EQ_L1_L3, ea);
		wr(REG_EQ_L0_L2, eb);
		rd(REG_EQ_L1_L3, ea);
		rd(REG_EQ_L0_L2, eb);
		chk(eq, {ea[3:0], eb[3:0], ea[7:4], eb[7:4]}, "eq map");
		wr(REG_GENERAL, 8'h01);
		chk(eq, {4{e4}}, "eq pins");
		$display("test eq done");
		for (int m = 0; m < 4; m++) begin
			wr(REG_GENERAL, 8'(m));
			lx = (m == 2) ? 4'hf : (m == 3) ? 4'h3 : 4'h0;
			chk({11'h000, usb, lanes}, {11'h000, m[0], lx}, "mode");
		end
		$display("test modes done");
		wr(REG_GENERAL, 8'hE4);
		rd(REG_GENERAL, 8'h04);
		chk({15'h0000, orient}, 16'h0001, "orient");
		wr(REG_GENERAL, 8'h0A);
		chk({12'h000, lanes}, 16'h0000, "pin low");
		up_pin = 1'b1;
		or_pin = 1'b1;
		tick(20);
		rd(REG_GENERAL, 8'h0E);
		chk({12'h000, lanes}, 16'h000F, "pin high");
		$display("test pins done");
		wr(REG_GENERAL, 8'h02);
		aux(AUX_ADDR_LANES, 8'h01);
		chk({12'h000, lanes}, 16'h0001, "count one");
		aux(AUX_ADDR_POWER, 8'h02);
		chk({12'h000, lanes}, 16'h0000, "power down");
		aux(20'h0_0102, 8'($random(seed)));
		rd(REG_SNOOP, 8'h41);
		wr(REG_LANE_CTL, 8'hD5);
		rd(REG_LANE_CTL, 8'h95);
		chk({10'h000, sbu, lanes}, 16'h001A, "snoop off");
		wr(REG_GENERAL, 8'h01);
		rd(REG_SNOOP, 8'h00);
		rd(8'h30, 8'h00);
		tick(4);
		chk({15'h0000, nack}, 16'h0000, "acks");
		chk(16'(exp_q.size()), 16'h0000, "pending reads");
		$display("test snoop done");
		give_verdict();
	end
endmodule
